// File: verilog/edm_pkg.sv
/*
 * shared constants for the contactor feedback monitor: register map,
 * field positions, reset values, logic-cycle timing and state types.
 * assumes a 100 MHz system clock and a 1 ms logic cycle.
 */
package edm_pkg;

	// clock and logic-cycle timing
	localparam int SYS_CLK_MHZ      = 100;
	localparam int LOGIC_CYCLE_US   = 1000;
	localparam int LOGIC_CYCLE_CLKS = LOGIC_CYCLE_US * SYS_CLK_MHZ;
	localparam int TICKS_PER_MS     = 1000 / LOGIC_CYCLE_US;

	// double pulse reset sequence must finish under this time
	localparam int RESET_SEQ_MS     = 5000;
	localparam int RESET_SEQ_TICKS  = RESET_SEQ_MS * TICKS_PER_MS;

	// half period of the clear indicator flashing
	localparam int BLINK_HALF_MS    = 250;
	localparam int BLINK_TICKS      = BLINK_HALF_MS * TICKS_PER_MS;

	// widths
	localparam int WINDOW_W         = 16;
	localparam int WIN_CNT_W        = 24;
	localparam int BLINK_W          = 16;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_WINDOW = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// control fields
	localparam int CTRL_CLEAR_EN_BIT = 0;
	localparam int CTRL_ERR_EN_BIT   = 1;

	// status fields
	localparam int ST_FAULT_BIT  = 0;
	localparam int ST_LED_BIT    = 1;
	localparam int ST_ERR_BIT    = 2;
	localparam int ST_FBK_BIT    = 3;
	localparam int ST_MON_BIT    = 4;
	localparam int ST_SSO_BIT    = 5;

	// reset values
	localparam logic [1:0]          CTRL_RST   = 2'h0;
	localparam logic [WINDOW_W-1:0] WINDOW_RST = 16'h0064;

	// double pulse detector states
	typedef enum logic [1:0] {
		PR_IDLE,
		PR_HIGH1,
		PR_LOW1,
		PR_HIGH2
	} pulse_state_t;

endpackage : edm_pkg

// File: verilog/cycle_if.sv
/*
 * carrier between the monitor top and its two helpers: the logic-cycle
 * tick, the reset button level and the system reset request.
 * assumes all three parties run on sys_clk.
 */
interface cycle_if;
	logic tick;   // one sys_clk pulse per logic cycle
	logic level;  // registered reset button level
	logic fire;   // one-cycle system reset request

	modport gen (output tick);
	modport det (input tick, input level, output fire);
	modport top (input tick, input fire, output level);
endinterface : cycle_if

// File: verilog/logic_tick_gen.sv
/*
 * logic-cycle tick generator: divides sys_clk down to one pulse per
 * logic cycle. assumes TICK_CYCLES sys_clk periods per logic cycle.
 */
module logic_tick_gen
	import edm_pkg::*;
#(
	parameter int TICK_CYCLES = LOGIC_CYCLE_CLKS
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// tick out
	cycle_if.gen      bus
);
	localparam int DW = $clog2(TICK_CYCLES);

	initial begin
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
	end

	logic [DW-1:0] div_ff;
	logic          tick_ff;

	// free running divider, tick on wrap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (div_ff == DW'(TICK_CYCLES - 1)) begin
			div_ff  <= '0;
			tick_ff <= 1'b1;
		end else begin
			div_ff  <= div_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	assign bus.tick = tick_ff;

endmodule : logic_tick_gen

// File: verilog/double_pulse_reset.sv
/*
 * double off-on-off pulse detector on the reset button, judged in
 * logic cycles. assumes level is already registered to sys_clk.
 */
module double_pulse_reset
	import edm_pkg::*;
#(
	parameter int LIMIT_TICKS = RESET_SEQ_TICKS
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// tick, level in, reset request out
	cycle_if.det      bus
);
	localparam int TW = $clog2(LIMIT_TICKS + 1);

	initial begin
		if (LIMIT_TICKS < 2)
			$error("LIMIT_TICKS must be at least 2");
	end

	pulse_state_t  state_ff;
	logic [TW-1:0] timer_ff;
	logic          prev_ff;
	logic          fire_ff;
	logic          rise;
	logic          fall;
	logic          expire;

	assign rise   = bus.level && !prev_ff;
	assign fall   = !bus.level && prev_ff;
	// a late sequence is dropped before its last edge can count
	assign expire = bus.tick && timer_ff == TW'(LIMIT_TICKS - 1);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			prev_ff <= 1'b0;
		else
			prev_ff <= bus.level;
	end

	// sequence state, timed from the first rising edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= PR_IDLE;
			timer_ff <= '0;
			fire_ff  <= 1'b0;
		end else begin
			fire_ff <= 1'b0;
			if (state_ff != PR_IDLE && bus.tick)
				timer_ff <= timer_ff + 1'b1;
			unique case (state_ff)
				PR_IDLE: begin
					timer_ff <= '0;
					if (rise)
						state_ff <= PR_HIGH1;
				end
				PR_HIGH1: begin
					if (expire)
						state_ff <= PR_IDLE;
					else if (fall)
						state_ff <= PR_LOW1;
				end
				PR_LOW1: begin
					if (expire)
						state_ff <= PR_IDLE;
					else if (rise)
						state_ff <= PR_HIGH2;
				end
				PR_HIGH2: begin
					if (expire) begin
						state_ff <= PR_IDLE;
					end else if (fall) begin
						state_ff <= PR_IDLE;
						fire_ff  <= 1'b1;
					end
				end
			endcase
		end
	end

	assign bus.fire = fire_ff;

	property p_fire_in_time;
		@(posedge sys_clk) disable iff (rst)
		$rose(fire_ff) |-> $past(state_ff) == PR_HIGH2 && $past(timer_ff) < TW'(LIMIT_TICKS);
	endproperty
	a_fire_in_time: assert property (p_fire_in_time) else $error("late reset fired");

	property p_no_fire_late;
		@(posedge sys_clk) disable iff (rst)
		expire && state_ff != PR_IDLE |=> state_ff == PR_IDLE && !fire_ff;
	endproperty
	a_no_fire_late: assert property (p_no_fire_late) else $error("expiry ignored");

	c_fire: cover property (@(posedge sys_clk) disable iff (rst) fire_ff);

endmodule : double_pulse_reset

// File: verilog/edm_feedback_monitor.sv
/*
 * contactor feedback monitor with double pulse system reset, apb slave.
 * assumes synchronous inputs, 100 MHz sys_clk, one apb master.
 */
// The implementer's own choices: the register offsets and the APB register port.
// Summary of operation
// - with the switching output high the feedback must read low, with it low the feedback high.
// - feedback not reaching the opposite level within the window drives the monitor output low.
// - a feedback timing fault flashes the clear indicator of that switching output.
// - with error output enabled it is high while a feedback fault is latched, else low.
// - the feedback window is settable by software in milliseconds.
// - the clear input acts only when the clear option is enabled.
// - an enabled clear input at 1 after repair removes the latched fault.
// - two off-on-off pulses on the reset input within 5 s issue a system reset.
// - a double pulse sequence taking longer than 5 s issues no system reset.
// - the system reset clears latched feedback faults without a power cycle.
module edm_feedback_monitor
	import edm_pkg::*;
#(
	parameter int TICK_CYCLES = LOGIC_CYCLE_CLKS
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// monitored path
	input  wire logic        monitor_in,
	input  wire logic        safety_switching_output,
	input  wire logic        feedback_k,
	input  wire logic        clear_in,
	output logic             monitor_out,
	output logic             clear_led,
	output logic             error_out,
	// system reset
	input  wire logic        reset_button,
	output logic             sys_reset_out
);

	initial begin
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
	end

	cycle_if cyc ();

	// helpers
	logic_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (cyc)
	);

	double_pulse_reset #(
		.LIMIT_TICKS (RESET_SEQ_TICKS)
	) u_pulse (
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (cyc)
	);

	// registers
	logic [1:0]           ctrl_ff;
	logic [WINDOW_W-1:0]  window_ff;
	logic                 pready_ff;
	logic [31:0]          prdata_ff;
	logic                 pslverr_ff;
	logic                 button_ff;
	logic                 fault_ff;
	logic [WIN_CNT_W-1:0] win_cnt_ff;
	logic [BLINK_W-1:0]   blink_ff;
	logic                 clear_led_ff;
	logic                 monitor_out_ff;
	logic                 error_out_ff;
	logic                 sys_reset_ff;

	// combinational terms
	logic                 acc;
	logic                 hit;
	logic                 wr_now;
	logic [31:0]          rd_data;
	logic                 clear_en;
	logic                 err_en;
	logic                 mismatch;
	logic [WIN_CNT_W-1:0] window_ticks;
	logic                 fault_set;
	logic                 clear_req;
	logic                 blink_wrap;

	assign acc      = psel && penable;
	assign hit      = paddr == ADDR_CTRL || paddr == ADDR_WINDOW || paddr == ADDR_STATUS;
	// writes land on the edge where the master sees pready high
	assign wr_now   = acc && pready_ff && pwrite;
	assign clear_en = ctrl_ff[CTRL_CLEAR_EN_BIT];
	assign err_en   = ctrl_ff[CTRL_ERR_EN_BIT];

	// feedback must sit opposite to the switching output
	assign mismatch = feedback_k == safety_switching_output;

	// ms to logic cycles; product fits since window is 16 bits
	assign window_ticks = WIN_CNT_W'(window_ff) * WIN_CNT_W'(TICKS_PER_MS);

	// fault when the mismatch outlasts the window
	assign fault_set = !fault_ff && mismatch && cyc.tick
	                   && win_cnt_ff >= window_ticks;

	// clear input only honoured when enabled and the feedback is healthy again
	assign clear_req = (clear_en && clear_in && !mismatch) || cyc.fire;

	assign blink_wrap = cyc.tick && blink_ff == BLINK_W'(BLINK_TICKS - 1);

	// read mux
	always_comb begin
		rd_data = '0;
		unique case (paddr)
			ADDR_CTRL:   rd_data[1:0] = ctrl_ff;
			ADDR_WINDOW: rd_data[WINDOW_W-1:0] = window_ff;
			ADDR_STATUS: begin
				rd_data[ST_FAULT_BIT] = fault_ff;
				rd_data[ST_LED_BIT]   = clear_led_ff;
				rd_data[ST_ERR_BIT]   = error_out_ff;
				rd_data[ST_FBK_BIT]   = feedback_k;
				rd_data[ST_MON_BIT]   = monitor_out_ff;
				rd_data[ST_SSO_BIT]   = safety_switching_output;
			end
			default:     rd_data = '0;
		endcase
	end

	// apb answer: one wait state so every bus output is registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (acc && !pready_ff) begin
			pready_ff  <= 1'b1;
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr_ff <= !hit;
		end else begin
			pready_ff  <= 1'b0;
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ctrl_ff <= CTRL_RST;
		else if (wr_now && paddr == ADDR_CTRL)
			ctrl_ff <= pwdata[1:0];
	end

	// window register in milliseconds
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			window_ff <= WINDOW_RST;
		else if (wr_now && paddr == ADDR_WINDOW)
			window_ff <= pwdata[WINDOW_W-1:0];
	end

	// reset button registered before the pulse detector
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			button_ff <= 1'b0;
		else
			button_ff <= reset_button;
	end
	assign cyc.level = button_ff;

	// mismatch timer, counted in logic cycles and restarted on agreement
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			win_cnt_ff <= '0;
		else if (!mismatch || fault_ff)
			win_cnt_ff <= '0;
		else if (cyc.tick && win_cnt_ff != '1)
			win_cnt_ff <= win_cnt_ff + 1'b1;
	end

	// latched fault; a new fault wins over a clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			fault_ff <= 1'b0;
		else if (fault_set)
			fault_ff <= 1'b1;
		else if (clear_req)
			fault_ff <= 1'b0;
	end

	// monitor output follows its input unless a fault is latched
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			monitor_out_ff <= 1'b0;
		else
			monitor_out_ff <= monitor_in && !fault_ff && !fault_set;
	end

	// clear indicator flashing; the downstream block must not time the contactor itself
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blink_ff     <= '0;
			clear_led_ff <= 1'b0;
		end else if (!fault_ff) begin
			blink_ff     <= '0;
			clear_led_ff <= 1'b0;
		end else if (cyc.tick) begin
			blink_ff <= blink_wrap ? '0 : blink_ff + 1'b1;
			if (blink_wrap)
				clear_led_ff <= !clear_led_ff;
		end
	end

	// error output only when enabled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			error_out_ff <= 1'b0;
		else
			error_out_ff <= err_en && fault_ff;
	end

	// system reset pulse out
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sys_reset_ff <= 1'b0;
		else
			sys_reset_ff <= cyc.fire;
	end

	assign pready        = pready_ff;
	assign prdata        = prdata_ff;
	assign pslverr       = pslverr_ff;
	assign monitor_out   = monitor_out_ff;
	assign clear_led     = clear_led_ff;
	assign error_out     = error_out_ff;
	assign sys_reset_out = sys_reset_ff;

	// checks
	property p_timer_restart;
		@(posedge sys_clk) disable iff (rst)
		!mismatch |=> win_cnt_ff == '0;
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("timer kept");

	property p_fault_drops_out;
		@(posedge sys_clk) disable iff (rst)
		fault_ff |=> !monitor_out_ff;
	endproperty
	a_fault_drops_out: assert property (p_fault_drops_out) else $error("output high");

	property p_window_expiry;
		@(posedge sys_clk) disable iff (rst)
		!fault_ff && mismatch && cyc.tick && win_cnt_ff >= window_ticks |=> fault_ff;
	endproperty
	a_window_expiry: assert property (p_window_expiry) else $error("no fault");

	property p_led_blink;
		@(posedge sys_clk) disable iff (rst)
		fault_ff && blink_wrap |=> clear_led_ff != $past(clear_led_ff);
	endproperty
	a_led_blink: assert property (p_led_blink) else $error("led stuck");

	property p_led_off;
		@(posedge sys_clk) disable iff (rst)
		!fault_ff |=> !clear_led_ff;
	endproperty
	a_led_off: assert property (p_led_off) else $error("led lit");

	property p_err_out;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> error_out_ff == $past(err_en && fault_ff);
	endproperty
	a_err_out: assert property (p_err_out) else $error("error out wrong");

	property p_clear_gated;
		@(posedge sys_clk) disable iff (rst)
		fault_ff && !clear_en && !cyc.fire |=> fault_ff;
	endproperty
	a_clear_gated: assert property (p_clear_gated) else $error("fault lost");

	property p_clear_works;
		@(posedge sys_clk) disable iff (rst)
		fault_ff && clear_en && clear_in && !mismatch |=> !fault_ff;
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("clear ignored");

	property p_reset_clears;
		@(posedge sys_clk) disable iff (rst)
		cyc.fire && !fault_set |=> !fault_ff ##0 sys_reset_out;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset no clear");

	// healthy path: the monitor output is its input one clock late
	property p_monitor_follow;
		@(posedge sys_clk) disable iff (rst)
		!fault_ff && !fault_set |=> monitor_out_ff == $past(monitor_in);
	endproperty
	a_monitor_follow: assert property (p_monitor_follow) else $error("output not passed");

	// mismatch time advances by one per logic cycle until the fault latches
	property p_mismatch_count;
		@(posedge sys_clk) disable iff (rst)
		mismatch && !fault_ff && cyc.tick && win_cnt_ff != '1
		|=> win_cnt_ff == $past(win_cnt_ff) + 1'b1;
	endproperty
	a_mismatch_count: assert property (p_mismatch_count) else $error("timer not counting");

	// with the error output disabled it never rises
	property p_err_low;
		@(posedge sys_clk) disable iff (rst)
		!err_en |=> !error_out_ff;
	endproperty
	a_err_low: assert property (p_err_low) else $error("error out unmasked");

	// the system reset request is a single clock wide
	property p_sysrst_pulse;
		@(posedge sys_clk) disable iff (rst)
		sys_reset_ff |=> !sys_reset_ff;
	endproperty
	a_sysrst_pulse: assert property (p_sysrst_pulse) else $error("reset pulse too long");

	// bus answer: exactly one wait state, then pready for one clock
	property p_apb_wait;
		@(posedge sys_clk) disable iff (rst)
		psel && penable && !pready_ff |=> pready_ff;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("no bus answer");

	property p_pready_single;
		@(posedge sys_clk) disable iff (rst)
		pready_ff |=> !pready_ff;
	endproperty
	a_pready_single: assert property (p_pready_single) else $error("pready stuck");

	c_fault:  cover property (@(posedge sys_clk) disable iff (rst) $rose(fault_ff));
	c_clear:  cover property (@(posedge sys_clk) disable iff (rst) $fell(fault_ff) && !cyc.fire);
	c_rst_fx: cover property (@(posedge sys_clk) disable iff (rst) fault_ff && cyc.fire);
	// a full blink half period seen while the fault stays latched
	c_blink:  cover property (@(posedge sys_clk) disable iff (rst) fault_ff && $changed(clear_led_ff));

endmodule : edm_feedback_monitor

// File: tb/edm_contactor.sv
/*
 * behavioural model of the external contactor: its feedback contact
 * takes the opposite level of the switching output after a lag.
 * assumes the bench drives sso and stuck after rising edges of sys_clk.
 */
module edm_contactor (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// drive from the switching output
	input  wire logic       sso,
	input  wire logic       stuck,
	input  wire logic [7:0] lag,
	// feedback contact
	output logic            feedback_k
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt_ff;

	// contact follows the coil after lag+1 clocks; a welded contact never moves.
	// no timing supervision of its own, and it is the only block on this output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			feedback_k <= 1'b1;
			cnt_ff     <= 8'h00;
		end else if (stuck || feedback_k != sso) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff >= lag) begin
			feedback_k <= ~sso; // opposite level once settled
			cnt_ff     <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule : edm_contactor

// File: tb/tb.sv
/*
 * self-checking bench for the contactor feedback monitor.
 * assumes TICK_CYCLES of 4, so one logic cycle is four clocks.
 */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import edm_pkg::*;

	logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, monitor_in = 0, sso = 0, fbk, clear_in = 0;
	logic        monitor_out, clear_led, error_out, reset_button = 0, sys_reset_out;
	logic        stuck = 0;
	logic [3:0]  obs;
	int          n_errors = 0, checks = 0;

	// observed outputs indexed by the wait helpers
	assign obs = {error_out, sys_reset_out, clear_led, monitor_out};

	always #5 sys_clk = ~sys_clk;

	edm_feedback_monitor #(.TICK_CYCLES(4)) edm_feedback_monitor_inst (.sys_clk(sys_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.monitor_in(monitor_in), .safety_switching_output(sso), .feedback_k(fbk),
		.clear_in(clear_in), .monitor_out(monitor_out), .clear_led(clear_led),
		.error_out(error_out), .reset_button(reset_button), .sys_reset_out(sys_reset_out));

	edm_contactor edm_contactor_inst (.sys_clk(sys_clk), .rst(rst), .sso(sso),
		.stuck(stuck), .lag(8'h04), .feedback_k(fbk));

	task wrap_up;
		if (n_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// one apb transfer; waits for pready under a bound
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin n_errors++; wrap_up(); end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		`CHK(e, 1'b0)
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(r, exp)
		`CHK(e, experr)
	endtask : rd_chk

	// wait a bounded time for an output to reach a level
	task wait_on(input int idx, input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge sys_clk);
			if (obs[idx] === v) break;
		end
		`CHK(obs[idx], v)
		if (i == lim) wrap_up();
	endtask : wait_on

	// an output must hold its level for n clocks
	task hold_on(input int idx, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			if (obs[idx] !== v) bad = 1'b1;
		end
		`CHK(bad, 1'b0)
	endtask : hold_on

	task press(input int n);
		@(posedge sys_clk); reset_button <= 1'b1;
		repeat (n) @(posedge sys_clk);
		reset_button <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : press

	task t_regs;
		rd_chk(ADDR_CTRL, 32'h0, 1'b0);
		rd_chk(ADDR_WINDOW, {16'h0000, WINDOW_RST}, 1'b0);
		rd_chk(8'h0C, 32'h0, 1'b1);
		wr(ADDR_WINDOW, 32'h0000_0003);
		rd_chk(ADDR_WINDOW, 32'h0000_0003, 1'b0);
	endtask : t_regs

	task t_follow;
		@(posedge sys_clk); monitor_in <= 1'b1;
		wait_on(0, 1'b1, 4);
		repeat (3) begin
			@(posedge sys_clk); sso <= ~sso;
			hold_on(0, 1'b1, 40);
		end
		@(posedge sys_clk); monitor_in <= 1'b0;
		wait_on(0, 1'b0, 4);
		@(posedge sys_clk); monitor_in <= 1'b1;
		wait_on(0, 1'b1, 4);
	endtask : t_follow

	task t_fault;
		@(posedge sys_clk); stuck <= 1'b1; sso <= ~sso;
		hold_on(0, 1'b1, 6);
		wait_on(0, 1'b0, 40);
		hold_on(3, 1'b0, 8);
		wait_on(1, 1'b1, 1100);
		wait_on(1, 1'b0, 1100);
		wr(ADDR_STATUS, 32'hFFFF_FFFF);
		rd_chk(ADDR_STATUS, 32'h0000_0001, 1'b0);
		wr(ADDR_CTRL, 32'h0000_0002);
		wait_on(3, 1'b1, 4);
		rd_chk(ADDR_STATUS, 32'h0000_0005, 1'b0);
	endtask : t_fault

	task t_clear;
		@(posedge sys_clk); clear_in <= 1'b1;
		hold_on(0, 1'b0, 20);
		wr(ADDR_CTRL, 32'h0000_0003);
		rd_chk(ADDR_CTRL, 32'h0000_0003, 1'b0);
		hold_on(0, 1'b0, 20);
		@(posedge sys_clk); stuck <= 1'b0;
		wait_on(0, 1'b1, 20);
		wait_on(3, 1'b0, 4);
		@(posedge sys_clk); clear_in <= 1'b0;
	endtask : t_clear

	task t_sysrst;
		@(posedge sys_clk); stuck <= 1'b1; sso <= ~sso;
		wait_on(0, 1'b0, 40);
		@(posedge sys_clk); stuck <= 1'b0;
		hold_on(0, 1'b0, 20);
		press(20);
		// last release by hand: the one-clock pulse follows it within a few clocks
		@(posedge sys_clk);
		reset_button <= 1'b1;
		repeat (20) @(posedge sys_clk);
		reset_button <= 1'b0;
		wait_on(2, 1'b1, 8);
		wait_on(0, 1'b1, 4);
		rd_chk(ADDR_STATUS, 32'h0000_0030, 1'b0);
	endtask : t_sysrst

	// each phase 7000 clocks: the last fall comes 21000 clocks after the first
	// rise, past the 20000 clock limit, so the sequence must be dropped
	task t_slow;
		repeat (2) begin
			@(posedge sys_clk);
			reset_button <= 1'b1;
			hold_on(2, 1'b0, 7000);
			reset_button <= 1'b0;
			hold_on(2, 1'b0, 7000);
		end
		`CHK(monitor_out, 1'b1)
	endtask : t_slow

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_follow();
		t_fault();
		t_clear();
		t_sysrst();
		t_slow();
		wrap_up();
	end
endmodule : tb
